/* File: inc/edmmc_pkg.sv */
// Constants, layouts and helpers for the data-move memory control block
package edmmc_pkg;

    // Special-function register addresses
    localparam logic [7:0] ADDR_STRETCH  = 8'h8E;
    localparam logic [7:0] ADDR_PERMIT   = 8'h8F;
    localparam logic [7:0] ADDR_PAGE     = 8'h92;
    localparam logic [7:0] ADDR_CFG_ADDR = 8'h93;
    localparam logic [7:0] ADDR_CFG_DATA = 8'h94;
    localparam logic [7:0] ADDR_MAP_BP   = 8'h95;

    // Reset values
    localparam logic [7:0] RST_STRETCH  = 8'h01;
    localparam logic [7:0] RST_PERMIT   = 8'h00;
    localparam logic [7:0] RST_PAGE     = 8'h00;
    localparam logic [7:0] RST_CFG_ADDR = 8'h00;
    localparam logic [7:0] RST_CFG_DATA = 8'h00;
    localparam logic [7:0] RST_MAP_BP   = 8'h00;

    // Field positions
    localparam int STRETCH_LSB = 0;
    localparam int STRETCH_W   = 3;
    localparam int TDIV_LSB    = 3;
    localparam int TDIV_W      = 3;
    localparam int PERMIT_BIT  = 0;
    localparam int MAP_BIT     = 0;
    localparam int BP_BIT      = 7;

    // Timing in system clocks
    localparam int CLK_PER_INSTR    = 4;
    localparam int BASE_INSTR       = 2;
    localparam int STROBE_BASE_CLKS = 2;
    localparam int STROBE_STEP_CLKS = 4;
    localparam int STROBE_START_CLK = 4;
    localparam int CNT_W            = 6;

    // Extended SRAM windows and sizes
    localparam logic [15:0] SRAM_LO_BASE = 16'h0000;
    localparam logic [15:0] SRAM_HI_BASE = 16'h8400;
    localparam int          SRAM_BYTES   = 1024;
    localparam int          CFG_BYTES    = 128;

    typedef enum {SEQ_IDLE, SEQ_RUN} edmmc_seq_state_type;

    function automatic logic [CNT_W-1:0] edmmc_strobe_width(
        input logic [STRETCH_W-1:0] s);
        if (s == 3'h0)
        begin
            return CNT_W'(STROBE_BASE_CLKS);
        end
        return CNT_W'(STROBE_STEP_CLKS * int'(s));
    endfunction : edmmc_strobe_width

    function automatic logic [CNT_W-1:0] edmmc_move_clks(
        input logic [STRETCH_W-1:0] s);
        return CNT_W'(CLK_PER_INSTR * (BASE_INSTR + int'(s)));
    endfunction : edmmc_move_clks

endpackage : edmmc_pkg

/* File: hdl/edmmc_seq.sv */
// Data-move timing sequencer: instruction length and read/write strobes
module edmmc_seq
    import edmmc_pkg::*;
(
    input  wire logic                 clk,
    input  wire logic                 arst_n,
    input  wire logic                 start,
    input  wire logic                 external,
    input  wire logic                 we,
    input  wire logic [STRETCH_W-1:0] stretch,
    output logic                      busy,
    output logic                      done_q,
    output logic                      sample_q,
    output logic                      rd_n_q,
    output logic                      wr_n_q
);

    edmmc_seq_state_type st_q, st_d;
    logic [CNT_W-1:0] cnt_q, cnt_d, len_q, len_d, wid_q, wid_d;
    logic             ext_q, ext_d, we_q, we_d;
    logic             done_d, sample_d, rd_n_d, wr_n_d, strobe;

    assign busy = (st_q == SEQ_RUN);

    ////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        st_d   = st_q;
        cnt_d  = cnt_q;
        len_d  = len_q;
        wid_d  = wid_q;
        ext_d  = ext_q;
        we_d   = we_q;
        done_d = 1'b0;
        case (st_q)
            SEQ_IDLE:
            begin
                if (start)
                begin
                    st_d  = SEQ_RUN;
                    cnt_d = '0;
                    ext_d = external;
                    we_d  = we;
                    // Internal moves never stretch
                    len_d = external ? edmmc_move_clks(stretch)
                                     : edmmc_move_clks(3'h0);
                    wid_d = edmmc_strobe_width(stretch);
                end
            end
            SEQ_RUN:
            begin
                cnt_d = cnt_q + 6'h01;
                if (cnt_q == len_q - 6'h01)
                begin
                    st_d   = SEQ_IDLE;
                    done_d = 1'b1;
                end
            end
            default:
            begin
                st_d = SEQ_IDLE;
            end
        endcase
        strobe = (st_d == SEQ_RUN) && ext_d
              && (cnt_d >= CNT_W'(STROBE_START_CLK))
              && (cnt_d < CNT_W'(STROBE_START_CLK) + wid_d);
        rd_n_d   = !(strobe && !we_d);
        wr_n_d   = !(strobe && we_d);
        sample_d = strobe && !we_d
                && (cnt_d == CNT_W'(STROBE_START_CLK) + wid_d - 6'h01);
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st_q     <= SEQ_IDLE;
            cnt_q    <= '0;
            len_q    <= '0;
            wid_q    <= '0;
            ext_q    <= 1'b0;
            we_q     <= 1'b0;
            done_q   <= 1'b0;
            sample_q <= 1'b0;
            rd_n_q   <= 1'b1;
            wr_n_q   <= 1'b1;
        end
        else
        begin
            st_q     <= st_d;
            cnt_q    <= cnt_d;
            len_q    <= len_d;
            wid_q    <= wid_d;
            ext_q    <= ext_d;
            we_q     <= we_d;
            done_q   <= done_d;
            sample_q <= sample_d;
            rd_n_q   <= rd_n_d;
            wr_n_q   <= wr_n_d;
        end
    end

endmodule : edmmc_seq

/* File: hdl/edmmc_top.sv */
// Data-move memory control: SFRs, address routing and strobe stretching
module edmmc_top
    import edmmc_pkg::*;
#(
    parameter int XSRAM_BYTES = SRAM_BYTES,
    parameter int CFG_DEPTH   = CFG_BYTES
)
(
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic [7:0]  sfr_addr,
    input  wire logic        sfr_wr,
    input  wire logic        sfr_rd,
    input  wire logic [7:0]  sfr_wdata,
    output logic      [7:0]  sfr_rdata_q,
    input  wire logic        xmove_req,
    input  wire logic        xmove_we,
    input  wire logic        xmove_ri,
    input  wire logic        xmove_flash,
    input  wire logic [7:0]  xmove_ri_lo,
    input  wire logic [15:0] xmove_dptr,
    input  wire logic [7:0]  xmove_wdata,
    output logic             xmove_busy_q,
    output logic             xmove_done,
    output logic      [7:0]  xmove_rdata_q,
    output logic      [15:0] mem_addr_q,
    output logic      [7:0]  mem_wdata_q,
    output logic             ext_rd_n,
    output logic             ext_wr_n,
    input  wire logic [7:0]  ext_data_i,
    output logic             ext_data_oe_q,
    input  wire logic        p2_ext_mode,
    input  wire logic [7:0]  p2_latch,
    output logic      [7:0]  p2_out_q,
    output logic             xsram_en_q,
    output logic             xsram_we_q,
    input  wire logic [7:0]  xsram_rdata,
    output logic             sram_map_select_q,
    output logic             flash_wr_stb_q,
    input  wire logic        program_memory_lock,
    input  wire logic        reset_sector_lock,
    output logic      [6:0]  cfg_addr_q,
    input  wire logic [7:0]  cfg_rdata,
    output logic             breakpoint_select_q,
    input  wire logic        bp_event,
    input  wire logic        bp_event_src
);

    if (XSRAM_BYTES > SRAM_BYTES || (XSRAM_BYTES & (XSRAM_BYTES - 1)) != 0
        || CFG_DEPTH > CFG_BYTES || CFG_DEPTH < 2)
    begin : g_bad_param
        $error("edmmc_top: unsupported memory size parameter");
    end

    ////////////////////////////////////////////////////////////////////////
    // Register group
    logic [STRETCH_W-1:0] stretch_q, stretch_d;
    logic [TDIV_W-1:0]    tdiv_q, tdiv_d;
    logic                 permit_q, permit_d, map_d, breakpoint_select_d;
    logic                 bp_src_q, bp_src_d;
    logic [7:0]           page_q, page_d, rdata_d;
    logic [6:0]           cfg_addr_d;
    logic [7:0]           cfg_data_q;

    always_comb
    begin
        stretch_d  = stretch_q;
        tdiv_d     = tdiv_q;
        permit_d   = permit_q;
        page_d     = page_q;
        cfg_addr_d = cfg_addr_q;
        map_d      = sram_map_select_q;
        breakpoint_select_d    = breakpoint_select_q;
        bp_src_d   = bp_event ? bp_event_src : bp_src_q;
        rdata_d    = sfr_rdata_q;
        if (sfr_wr)
        begin
            case (sfr_addr)
                ADDR_STRETCH:
                begin
                    stretch_d = sfr_wdata[STRETCH_LSB +: STRETCH_W];
                    tdiv_d    = sfr_wdata[TDIV_LSB +: TDIV_W];
                end
                ADDR_PERMIT:   permit_d   = sfr_wdata[PERMIT_BIT];
                ADDR_PAGE:     page_d     = sfr_wdata;
                ADDR_CFG_ADDR: cfg_addr_d = sfr_wdata[6:0];
                ADDR_MAP_BP:
                begin
                    map_d   = sfr_wdata[MAP_BIT];
                    breakpoint_select_d = sfr_wdata[BP_BIT];
                end
                default:       cfg_addr_d = cfg_addr_q;
            endcase
        end
        if (sfr_rd)
        begin
            rdata_d = 8'h00;
            case (sfr_addr)
                ADDR_STRETCH:
                begin
                    rdata_d[STRETCH_LSB +: STRETCH_W] = stretch_q;
                    rdata_d[TDIV_LSB +: TDIV_W]       = tdiv_q;
                end
                ADDR_PERMIT:   rdata_d[PERMIT_BIT] = permit_q;
                ADDR_PAGE:     rdata_d = page_q;
                ADDR_CFG_DATA: rdata_d = cfg_data_q;
                ADDR_MAP_BP:
                begin
                    rdata_d[MAP_BIT] = sram_map_select_q;
                    rdata_d[BP_BIT]  = bp_src_q;
                end
                default:       rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            stretch_q           <= RST_STRETCH[STRETCH_LSB +: STRETCH_W];
            tdiv_q              <= RST_STRETCH[TDIV_LSB +: TDIV_W];
            permit_q            <= RST_PERMIT[PERMIT_BIT];
            page_q              <= RST_PAGE;
            cfg_addr_q          <= RST_CFG_ADDR[6:0];
            cfg_data_q          <= RST_CFG_DATA;
            sram_map_select_q   <= RST_MAP_BP[MAP_BIT];
            breakpoint_select_q <= RST_MAP_BP[BP_BIT];
            bp_src_q            <= RST_MAP_BP[BP_BIT];
            sfr_rdata_q         <= 8'h00;
        end
        else
        begin
            stretch_q           <= stretch_d;
            tdiv_q              <= tdiv_d;
            permit_q            <= permit_d;
            page_q              <= page_d;
            cfg_addr_q          <= cfg_addr_d;
            cfg_data_q          <= cfg_rdata;
            sram_map_select_q   <= map_d;
            breakpoint_select_q <= breakpoint_select_d;
            bp_src_q            <= bp_src_d;
            sfr_rdata_q         <= rdata_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Transfer group
    logic        take, in_sram, is_flash, wr_ok, ext_act_q, ext_act_d;
    logic        seq_busy, seq_sample;
    logic [15:0] addr, base;
    logic [15:0] addr_d;
    logic [7:0]  wdata_d, rd_d, p2_d;
    logic        oe_d, xen_d, xwe_d, fstb_d, busy_d;

    assign take  = xmove_req && !seq_busy;
    assign addr  = xmove_ri ? {page_q, xmove_ri_lo} : xmove_dptr;
    assign base  = sram_map_select_q ? SRAM_HI_BASE : SRAM_LO_BASE;
    assign in_sram = (addr - base) < 16'(XSRAM_BYTES);
    assign is_flash = xmove_we && xmove_flash && !in_sram;
    assign wr_ok = permit_q && !program_memory_lock
                && !reset_sector_lock;

    always_comb
    begin
        addr_d    = mem_addr_q;
        wdata_d   = mem_wdata_q;
        ext_act_d = ext_act_q;
        oe_d      = ext_data_oe_q;
        xen_d     = 1'b0;
        xwe_d     = 1'b0;
        fstb_d    = 1'b0;
        rd_d      = xmove_rdata_q;
        busy_d    = take || (seq_busy && !xmove_done);
        if (take)
        begin
            addr_d    = addr;
            wdata_d   = xmove_wdata;
            ext_act_d = !in_sram && !is_flash;
            oe_d      = ext_act_d && xmove_we;
            xen_d     = in_sram;
            xwe_d     = in_sram && xmove_we;
            fstb_d    = is_flash && wr_ok;
        end
        else if (xmove_done)
        begin
            ext_act_d = 1'b0;
            oe_d      = 1'b0;
        end
        if (seq_sample)
        begin
            rd_d = ext_data_i;
        end
        else if (xsram_en_q && !xsram_we_q)
        begin
            rd_d = xsram_rdata;
        end
        p2_d = (ext_act_d && p2_ext_mode) ? addr_d[15:8] : p2_latch;
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            mem_addr_q     <= 16'h0000;
            mem_wdata_q    <= 8'h00;
            ext_act_q      <= 1'b0;
            ext_data_oe_q  <= 1'b0;
            xsram_en_q     <= 1'b0;
            xsram_we_q     <= 1'b0;
            flash_wr_stb_q <= 1'b0;
            xmove_rdata_q  <= 8'h00;
            xmove_busy_q   <= 1'b0;
            p2_out_q       <= 8'hFF;
        end
        else
        begin
            mem_addr_q     <= addr_d;
            mem_wdata_q    <= wdata_d;
            ext_act_q      <= ext_act_d;
            ext_data_oe_q  <= oe_d;
            xsram_en_q     <= xen_d;
            xsram_we_q     <= xwe_d;
            flash_wr_stb_q <= fstb_d;
            xmove_rdata_q  <= rd_d;
            xmove_busy_q   <= busy_d;
            p2_out_q       <= p2_d;
        end
    end

    edmmc_seq u_seq (
        .clk      (clk),
        .arst_n   (arst_n),
        .start    (take),
        .external (!in_sram && !is_flash),
        .we       (xmove_we),
        .stretch  (stretch_q),
        .busy     (seq_busy),
        .done_q   (xmove_done),
        .sample_q (seq_sample),
        .rd_n_q   (ext_rd_n),
        .wr_n_q   (ext_wr_n)
    );

    ////////////////////////////////////////////////////////////////////////
    // Checks
    logic [CNT_W-1:0]     low_cnt_q;
    logic [STRETCH_W-1:0] xs_q;

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            low_cnt_q <= '0;
            xs_q      <= RST_STRETCH[STRETCH_LSB +: STRETCH_W];
        end
        else
        begin
            low_cnt_q <= (ext_rd_n && ext_wr_n) ? '0 : low_cnt_q + 6'h01;
            xs_q      <= take ? stretch_q : xs_q;
        end
    end

    property p_stretch_store;
        @(posedge clk) disable iff (!arst_n)
        sfr_wr && sfr_addr == ADDR_STRETCH
            |=> stretch_q == $past(sfr_wdata[2:0]);
    endproperty
    a_stretch_store: assert property (p_stretch_store)
        else $error("stretch code not stored");

    property p_strobe_width;
        @(posedge clk) disable iff (!arst_n)
        $rose(ext_rd_n && ext_wr_n) |-> low_cnt_q == edmmc_strobe_width(xs_q);
    endproperty
    a_strobe_width: assert property (p_strobe_width)
        else $error("strobe width wrong");

    property p_ext_len;
        @(posedge clk) disable iff (!arst_n)
        take && !in_sram && !is_flash && stretch_q == 3'h1 |-> ##13 xmove_done;
    endproperty
    a_ext_len: assert property (p_ext_len)
        else $error("external move length wrong at stretch 1");

    property p_int_len;
        @(posedge clk) disable iff (!arst_n)
        take && in_sram |-> ##9 xmove_done;
    endproperty
    a_int_len: assert property (p_int_len)
        else $error("internal move not two instruction cycles");

    property p_read_data;
        @(posedge clk) disable iff (!arst_n)
        seq_sample |=> xmove_rdata_q == $past(ext_data_i);
    endproperty
    a_read_data: assert property (p_read_data)
        else $error("external read data not captured");

    property p_flash_gate;
        @(posedge clk) disable iff (!arst_n)
        flash_wr_stb_q |-> $past(permit_q && !program_memory_lock
                                 && !reset_sector_lock);
    endproperty
    a_flash_gate: assert property (p_flash_gate)
        else $error("flash write not blocked");

    property p_page_hi;
        @(posedge clk) disable iff (!arst_n)
        take && xmove_ri |=> mem_addr_q[15:8] == $past(page_q);
    endproperty
    a_page_hi: assert property (p_page_hi)
        else $error("page byte not used");

    property p_cfg_read;
        @(posedge clk) disable iff (!arst_n)
        sfr_rd && sfr_addr == ADDR_CFG_DATA
            |=> sfr_rdata_q == $past(cfg_data_q);
    endproperty
    a_cfg_read: assert property (p_cfg_read)
        else $error("config data readback wrong");

    property p_sram_window;
        @(posedge clk) disable iff (!arst_n)
        xsram_en_q |-> mem_addr_q[15:10] == (sram_map_select_q ? 6'h21 : 6'h00);
    endproperty
    a_sram_window: assert property (p_sram_window)
        else $error("extended SRAM decoded outside window");

    property p_bp_src;
        @(posedge clk) disable iff (!arst_n)
        bp_event ##1 sfr_rd && sfr_addr == ADDR_MAP_BP
            |=> sfr_rdata_q[BP_BIT] == $past(bp_event_src, 2);
    endproperty
    a_bp_src: assert property (p_bp_src)
        else $error("breakpoint source not reported");

    property p_unused_zero;
        @(posedge clk) disable iff (!arst_n)
        sfr_rd && sfr_addr == ADDR_PERMIT |=> sfr_rdata_q[7:1] == 7'h00;
    endproperty
    a_unused_zero: assert property (p_unused_zero)
        else $error("unused bits not zero");

    c_max_stretch: cover property (@(posedge clk) disable iff (!arst_n)
        take && !in_sram && stretch_q == 3'h7);
    c_flash_block: cover property (@(posedge clk) disable iff (!arst_n)
        take && is_flash && !wr_ok);
    c_ri_ext: cover property (@(posedge clk) disable iff (!arst_n)
        take && xmove_ri && !in_sram);
    c_sram_hi: cover property (@(posedge clk) disable iff (!arst_n)
        take && in_sram && sram_map_select_q);

endmodule : edmmc_top

/* File: verification/edmmc_mem_model.sv */
// Behavioural external data memory behind the read/write strobes
module edmmc_mem_model
(
    input  wire logic        clk,
    input  wire logic [15:0] addr,
    input  wire logic [7:0]  wdata,
    input  wire logic        rd_n,
    input  wire logic        wr_n,
    input  wire logic        oe,
    output logic      [7:0]  rdata
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] mem [256];

    initial
    begin
        foreach (mem[i])
        begin
            mem[i] = 8'(i) ^ 8'hA5;
        end
    end

    always @(posedge clk)
    begin
        if (!wr_n && oe)
        begin
            mem[addr[7:0]] = wdata;
        end
    end

    // Bus off shows the inverse so a stale sample cannot pass
    assign rdata = rd_n ? ~mem[addr[7:0]] : mem[addr[7:0]];
endmodule : edmmc_mem_model

/* File: verification/edmmc_top_test.sv */
// Self-checking bench for the data-move memory control block
module edmmc_top_test import edmmc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk, arst_n, sfr_wr, sfr_rd, xmove_req, xmove_we;
    logic        xmove_ri, xmove_flash, p2_ext_mode, program_memory_lock;
    logic        reset_sector_lock, bp_event, bp_event_src, xmove_busy_q;
    logic        xmove_done, ext_rd_n, ext_wr_n, ext_data_oe_q, xsram_en_q;
    logic        xsram_we_q, sram_map_select_q, flash_wr_stb_q;
    logic        breakpoint_select_q;
    logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata_q, xmove_ri_lo, xmove_wdata;
    logic [7:0]  xmove_rdata_q, mem_wdata_q, ext_data_i, p2_latch, p2_out_q;
    logic [7:0]  xsram_rdata, cfg_rdata, m_p2;
    logic [15:0] xmove_dptr, mem_addr_q;
    logic [6:0]  cfg_addr_q;
    int          bad_count, total_checks, m_clks, m_sw, m_fp, m_bz;
    logic [2:0]  m_xw;

    initial clk = 1'b0;
    always #2 clk = ~clk;
    assign xsram_rdata = 8'hC3;
    assign cfg_rdata = {cfg_addr_q, 1'b1} ^ 8'h3C;

    edmmc_top u_edmmc_top (
        .clk, .arst_n, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata_q,
        .xmove_req, .xmove_we, .xmove_ri, .xmove_flash, .xmove_ri_lo,
        .xmove_dptr, .xmove_wdata, .xmove_busy_q, .xmove_done,
        .xmove_rdata_q, .mem_addr_q, .mem_wdata_q, .ext_rd_n, .ext_wr_n,
        .ext_data_i, .ext_data_oe_q, .p2_ext_mode, .p2_latch, .p2_out_q,
        .xsram_en_q, .xsram_we_q, .xsram_rdata, .sram_map_select_q,
        .flash_wr_stb_q, .program_memory_lock, .reset_sector_lock,
        .cfg_addr_q, .cfg_rdata, .breakpoint_select_q, .bp_event,
        .bp_event_src
    );

    edmmc_mem_model u_edmmc_mem_model (
        .clk(clk), .addr(mem_addr_q), .wdata(mem_wdata_q), .rd_n(ext_rd_n),
        .wr_n(ext_wr_n), .oe(ext_data_oe_q), .rdata(ext_data_i)
    );

    ////////////////////////////////////////////////////////////
    task automatic final_report;
        if (bad_count == 0 && total_checks > 0)
        begin
            $display("All checks passed");
        end
        else
        begin
            $display("Checks failed");
        end
        $finish;
    endtask : final_report

    task automatic chk(input string nm, input logic [15:0] e, g);
        total_checks++;
        if (g !== e)
        begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic sfr_write(input logic [7:0] a, d);
        @(negedge clk);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(negedge clk);
        sfr_wr = 1'b0;
    endtask : sfr_write

    task automatic rd_chk(input string nm, input logic [7:0] a, e);
        @(negedge clk);
        sfr_addr = a;
        sfr_rd = 1'b1;
        @(negedge clk);
        sfr_rd = 1'b0;
        chk(nm, 16'(e), 16'(sfr_rdata_q));
    endtask : rd_chk

    // Kind is {write, indirect, flash, request}; m_clks numbers the edges from
    // the take edge as 1 up to the one at which done is sampled high
    task automatic move(input logic [3:0] k, input logic [15:0] a,
                        input logic [7:0] wd);
        @(negedge clk);
        {xmove_we, xmove_ri, xmove_flash, xmove_req} = k;
        xmove_dptr = a;
        xmove_ri_lo = a[7:0];
        xmove_wdata = wd;
        @(posedge clk);
        #1;
        m_fp = int'(flash_wr_stb_q);
        m_bz = int'(xmove_busy_q);
        m_xw = {xsram_en_q, xsram_we_q, ext_data_oe_q};
        m_sw = 0;
        @(negedge clk);
        xmove_req = 1'b0;
        for (m_clks = 2; m_clks < 100; m_clks++)
        begin
            @(posedge clk);
            #1;
            m_sw += int'(!ext_rd_n || !ext_wr_n);
            m_fp += int'(flash_wr_stb_q);
            m_bz += int'(xmove_busy_q);
            if (m_clks == 2)
            begin
                m_p2 = p2_out_q;
            end
            if (xmove_done === 1'b1)
            begin
                break;
            end
        end
        if (m_clks == 100)
        begin
            chk("move_timeout", 16'h0001, 16'h0000);
            final_report();
        end
    endtask : move

    task automatic t_reset;
        rd_chk("stretch", ADDR_STRETCH, 8'h01);
        rd_chk("permit", ADDR_PERMIT, 8'h00);
        rd_chk("page", ADDR_PAGE, 8'h00);
        rd_chk("map_bp", ADDR_MAP_BP, 8'h00);
        rd_chk("unmapped", 8'h80, 8'h00);
        move(4'h1, 16'h2000, 8'h00);
        chk("reset_len", 16'd13, 16'(m_clks));
    endtask : t_reset

    task automatic t_stretch;
        logic [2:0] s;
        for (int i = 0; i < 8; i++)
        begin
            s = 3'(i);
            sfr_write(ADDR_STRETCH, {5'b11101, s});
            rd_chk("stretch_rb", ADDR_STRETCH, {5'b00101, s});
            move(4'h1, {8'h40 + 8'(i), 8'h10}, 8'h00);
            chk("ext_len", 16'(4 * (2 + i) + 1), 16'(m_clks));
            chk("busy", 16'(4 * (2 + i) + 1), 16'(m_bz));
            chk("strobe", 16'(i == 0 ? 2 : 4 * i), 16'(m_sw));
            chk("p2_high", 16'(8'h40 + 8'(i)), 16'(m_p2));
            chk("rd_data", 16'h00B5, 16'(xmove_rdata_q));
        end
    endtask : t_stretch

    task automatic t_sram;
        move(4'h9, 16'h1234, 8'h5E);
        chk("wr_strobe", 16'd28, 16'(m_sw));
        chk("ext_oe", 16'h0001, 16'(m_xw));
        chk("wr_data", 16'h005E, 16'(mem_wdata_q));
        move(4'h1, 16'h1234, 8'h00);
        chk("rd_back", 16'h005E, 16'(xmove_rdata_q));
        move(4'h1, 16'h03FF, 8'h00);
        chk("sram_len", 16'd9, 16'(m_clks));
        chk("sram_data", 16'h00C3, 16'(xmove_rdata_q));
        move(4'h1, 16'h0400, 8'h00);
        chk("above_sram", 16'd37, 16'(m_clks));
        sfr_write(ADDR_MAP_BP, 8'h01);
        move(4'h1, 16'h03FF, 8'h00);
        chk("sram_moved", 16'd37, 16'(m_clks));
        move(4'h9, 16'h87FF, 8'h11);
        chk("sram_hi_len", 16'd9, 16'(m_clks));
        chk("sram_hi_stb", 16'd0, 16'(m_sw));
        chk("xsram_we", 16'h0006, 16'(m_xw));
    endtask : t_sram

    task automatic t_page;
        sfr_write(ADDR_PAGE, 8'hAB);
        move(4'h5, 16'h0034, 8'h00);
        chk("ri_addr", 16'hAB34, mem_addr_q);
        chk("ri_p2", 16'h00AB, 16'(m_p2));
    endtask : t_page

    task automatic t_flash;
        logic [2:0] c;
        sfr_write(ADDR_MAP_BP, 8'h00);
        for (int i = 0; i < 8; i++)
        begin
            c = 3'(i);
            sfr_write(ADDR_PERMIT, {7'h7F, c[2]});
            {program_memory_lock, reset_sector_lock} = c[1:0];
            move(4'hB, 16'h1000, 8'h77);
            chk("flash_stb", 16'(c == 3'b100), 16'(m_fp));
        end
        {program_memory_lock, reset_sector_lock} = 2'b00;
        rd_chk("permit_rb", ADDR_PERMIT, 8'h01);
    endtask : t_flash

    task automatic t_cfg;
        sfr_write(ADDR_CFG_ADDR, 8'h85);
        chk("cfg_addr", 16'h0005, 16'(cfg_addr_q));
        rd_chk("cfg_data", ADDR_CFG_DATA, 8'h37);
        rd_chk("cfg_addr_wo", ADDR_CFG_ADDR, 8'h00);
        sfr_write(ADDR_CFG_DATA, 8'hFF);
        rd_chk("cfg_data_ro", ADDR_CFG_DATA, 8'h37);
    endtask : t_cfg

    task automatic t_bp;
        sfr_write(ADDR_MAP_BP, 8'hFF);
        chk("bp_sel", 16'h0001, 16'(breakpoint_select_q));
        chk("map_sel", 16'h0001, 16'(sram_map_select_q));
        for (int i = 0; i < 2; i++)
        begin
            @(negedge clk);
            bp_event = 1'b1;
            bp_event_src = 1'(i);
            @(negedge clk);
            bp_event = 1'b0;
            sfr_addr = ADDR_MAP_BP;
            sfr_rd = 1'b1;
            @(negedge clk);
            sfr_rd = 1'b0;
            chk("bp_src", 16'({1'(i), 7'h01}), 16'(sfr_rdata_q));
        end
        sfr_write(ADDR_MAP_BP, 8'h00);
        chk("bp_sel_clr", 16'h0000, 16'(breakpoint_select_q));
        rd_chk("bp_hold", ADDR_MAP_BP, 8'h80);
    endtask : t_bp

    ////////////////////////////////////////////////////////////
    initial
    begin
        bad_count = 0;
        total_checks = 0;
        {arst_n, sfr_wr, sfr_rd, xmove_req, xmove_we, xmove_ri} = '0;
        {xmove_flash, program_memory_lock, reset_sector_lock} = '0;
        {bp_event, bp_event_src} = '0;
        {sfr_addr, sfr_wdata, xmove_ri_lo, xmove_wdata, xmove_dptr} = '0;
        p2_ext_mode = 1'b1;
        p2_latch = 8'h3C;
        repeat (8) @(posedge clk);
        @(negedge clk);
        arst_n = 1'b1;
        t_reset();
        t_stretch();
        t_sram();
        t_page();
        t_flash();
        t_cfg();
        t_bp();
        final_report();
    end
endmodule : edmmc_top_test
